// ==== design/ebwrh_pkg.sv ====
// package of constants for the external bus wait, ready and hold block
package ebwrh_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] REG_PMODE_IDX = 8'h5e;
    localparam logic [7:0] REG_STAT_IDX = 8'h5f;
    localparam int DEC_W = 12;
    // processor mode register fields
    localparam int PM_MODE_LSB = 0;
    localparam int PM_WAIT_BIT = 2;
    localparam int PM_CLKSEL_BIT = 7;
    localparam logic [7:0] PMODE_RST = 8'h00;
    localparam logic [7:0] PMODE_MASK = 8'h87;
    // processor modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_EXP = 2'h1;
    localparam logic [1:0] MODE_MICRO = 2'h2;
    // status register fields
    localparam int ST_READY_BIT = 0;
    localparam int ST_HOLD_BIT = 1;
    localparam int ST_ACK_BIT = 2;
    localparam int ST_WAIT_BIT = 3;
    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    // extra internal clock cycles per external cycle under software wait
    localparam int WAIT_CYCLES = 1;
    // hand-over states of the bus
    typedef enum logic [1:0] {
        HS_RUN,
        HS_ACK,
        HS_FLOAT,
        HS_REL
    } ebwrh_hold_t;
    // byte address of a register index
    function automatic logic [DEC_W-1:0] ebwrh_byte_addr(input logic [7:0] idx);
        ebwrh_byte_addr = {2'h0, idx, 2'h0};
    endfunction : ebwrh_byte_addr
endpackage : ebwrh_pkg

// ==== design/ebwrh_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ebwrh_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // asynchronous input and synchronised output
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // two flops in series
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : ebwrh_sync
`default_nettype wire

// ==== design/ebwrh_top.sv ====
// external bus wait, ready and hold hand-over logic with ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
module ebwrh_top
    import ebwrh_pkg::*;
#(
    parameter int LOW_ADDR_W = 8,
    parameter int AD_W = 16,
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // pins from outside: bus clock, ready and hold requests
    input wire logic bus_clk_in,
    input wire logic ready_req_n,
    input wire logic hold_req_n,
    // bus interface unit side, same clock
    input wire logic biu_busy,
    input wire logic biu_last_clk,
    input wire logic biu_odd_first,
    input wire logic biu_cycle_start,
    input wire logic biu_ext_area,
    input wire logic [LOW_ADDR_W-1:0] biu_addr,
    input wire logic [AD_W-1:0] biu_ad,
    input wire logic biu_ad_oe,
    input wire logic biu_strobe_n,
    input wire logic biu_rw,
    input wire logic upper_byte_enable_n_in,
    input wire logic biu_ale,
    input wire logic [PORT_W-1:0] port_four_in,
    // clock gating toward the core
    output logic cpu_clk_run,
    output logic int_clk_run,
    output logic wdt_run,
    output logic wait_stall,
    // bus pins
    output logic [LOW_ADDR_W-1:0] addr_out,
    output logic addr_oe,
    output logic [AD_W-1:0] ad_out,
    output logic ad_oe,
    output logic strobe_n,
    output logic rw_out,
    output logic rw_oe,
    output logic upper_byte_enable_n,
    output logic ube_oe,
    output logic ale,
    output logic bus_grant_ack_n,
    output logic [PORT_W-1:0] port_four_out,
    output logic bus_clk_pin,
    output logic bus_clk_oe
);
    // elaboration checks
    if (LOW_ADDR_W < 1 || AD_W < 1 || PORT_W < 1) begin : g_bad_width
        $error("ebwrh_top: widths must be at least one");
    end
    if (WAIT_CYCLES < 1 || WAIT_CYCLES > 7) begin : g_bad_wait
        $error("ebwrh_top: wait count out of range");
    end

    localparam logic [2:0] WAIT_LOAD = 3'(WAIT_CYCLES);

    // synchronised pins
    logic [2:0] pins_s;
    logic phi_s;
    logic ready_n_s;
    logic hold_n_s;
    logic phi_d; // previous bus clock level

    // two flops on every pin input
    ebwrh_sync #(
        .WIDTH(3),
        .RST_VAL(3'h7)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({bus_clk_in, ready_req_n, hold_req_n}),
        .sync_out(pins_s)
    );
    assign phi_s = pins_s[2];
    assign ready_n_s = pins_s[1];
    assign hold_n_s = pins_s[0];

    // bus clock edges
    wire phi_rise = phi_s & ~phi_d;
    wire phi_fall = ~phi_s & phi_d;

    // registers and state
    logic [7:0] pmode; // processor mode register
    logic ready_state; // ready state active
    logic ready_exit; // high level seen, leave at next rise
    ebwrh_hold_t hstate; // bus hand-over state
    logic hold_pend; // hold accepted, acts at next rise
    logic rel_pend; // release seen, acts at next rise
    logic [2:0] wait_cnt; // remaining wait clocks
    logic wr_pend; // write data phase pending
    logic [DEC_W-1:0] wr_addr; // address of pending write

    // mode decode
    wire [1:0] mode = pmode[PM_MODE_LSB +: 2];
    wire ext_mode = (mode == MODE_EXP) || (mode == MODE_MICRO);
    wire wait_sel = pmode[PM_WAIT_BIT];
    wire clk_sel = pmode[PM_CLKSEL_BIT];
    wire clk_pin_en = (mode == MODE_MICRO) || ((mode == MODE_EXP) && clk_sel);

    // hand-over decode
    wire hold_any = (hstate != HS_RUN);
    wire floated = (hstate == HS_FLOAT) || (hstate == HS_REL);
    wire ack_low = (hstate == HS_ACK) || (hstate == HS_FLOAT);
    // internal clock runs while not in ready, so it drives the hold and wait steps below
    wire int_fall = phi_fall & ~ready_state;
    wire int_rise = phi_rise & ~ready_state;
    // hold may be judged when idle or at the last clock, not in an odd split's first cycle
    wire hold_window = ~biu_busy | (biu_last_clk & ~biu_odd_first);
    wire hold_accept = int_fall & ext_mode & ~hold_n_s & hold_window & ~hold_any & ~hold_pend;

    // ahb-lite decode
    wire ap_take = hsel & hready & htrans[1];
    wire [DEC_W-1:0] ap_addr = haddr[DEC_W-1:0];
    wire hit_pmode = (ap_addr == ebwrh_byte_addr(REG_PMODE_IDX));
    wire hit_stat = (ap_addr == ebwrh_byte_addr(REG_STAT_IDX));
    wire wr_pmode = wr_pend && (wr_addr == ebwrh_byte_addr(REG_PMODE_IDX));
    wire [7:0] stat_word = {4'h0, wait_stall, ~bus_grant_ack_n, hold_any, ready_state};
    wire [31:0] rd_word = hit_pmode ? {24'h0, pmode} :
                          hit_stat ? {24'h0, stat_word} : 32'h0;

    // previous bus clock level for edge finding
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phi_d <= 1'b1;
        end else begin
            phi_d <= phi_s;
        end
    end

    // bus slave: address phase capture, zero-wait okay answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            wr_pend <= ap_take & hwrite;
            if (ap_take) begin
                wr_addr <= ap_addr;
            end
            // read data registered from the address phase
            if (ap_take && !hwrite) begin
                hrdata <= rd_word;
            end
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // processor mode register, write in data phase, reserved bits stay zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pmode <= PMODE_RST;
        end else if (wr_pmode) begin
            pmode <= hwdata[7:0] & PMODE_MASK;
        end
    end

    // ready state: enter on low at fall, leave at rise after a high sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_state <= 1'b0;
            ready_exit <= 1'b0;
        end else if (!ready_state) begin
            ready_exit <= 1'b0;
            if (phi_fall && ext_mode && !ready_n_s) begin
                ready_state <= 1'b1;
            end
        end else if (phi_fall) begin
            ready_exit <= ready_n_s;
        end else if (phi_rise && ready_exit) begin
            ready_state <= 1'b0;
            ready_exit <= 1'b0;
        end
    end

    // hold hand-over: accept at fall, ack at rise, float one clock later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hstate <= HS_RUN;
            hold_pend <= 1'b0;
            rel_pend <= 1'b0;
        end else begin
            if (hold_accept) begin
                hold_pend <= 1'b1;
            end
            // release judged at every internal clock fall while granted
            if (int_fall && ack_low) begin
                rel_pend <= hold_n_s;
            end
            if (int_rise) begin
                unique case (hstate)
                    HS_RUN: begin
                        if (hold_pend) begin
                            hstate <= HS_ACK;
                            hold_pend <= 1'b0;
                        end
                    end
                    HS_ACK: begin
                        if (rel_pend) begin
                            hstate <= HS_REL;
                            rel_pend <= 1'b0;
                        end else begin
                            hstate <= HS_FLOAT;
                        end
                    end
                    HS_FLOAT: begin
                        if (rel_pend) begin
                            hstate <= HS_REL;
                            rel_pend <= 1'b0;
                        end
                    end
                    HS_REL: begin
                        hstate <= HS_RUN;
                    end
                endcase
            end
        end
    end

    // software wait on external cycles only, counted in internal clocks
    wire wait_start = biu_cycle_start & biu_ext_area & wait_sel & (wait_cnt == 3'h0);
    wire [2:0] next_wait_cnt = wait_start ? WAIT_LOAD :
                               (int_rise && wait_cnt != 3'h0) ? wait_cnt - 3'h1 : wait_cnt;

    // wait counter and stall flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt <= 3'h0;
            wait_stall <= 1'b0;
        end else begin
            wait_cnt <= next_wait_cnt;
            wait_stall <= (next_wait_cnt != 3'h0);
        end
    end

    // clock gating toward core and watchdog
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_clk_run <= 1'b1;
            int_clk_run <= 1'b1;
            wdt_run <= 1'b1;
        end else begin
            cpu_clk_run <= ~ready_state & ~hold_any;
            int_clk_run <= ~ready_state;
            wdt_run <= ~hold_any;
        end
    end

    // next pin values; ready keeps every pin but the bus clock pin where it was
    wire [LOW_ADDR_W-1:0] next_addr_out = ready_state ? addr_out : biu_addr;
    wire next_addr_oe = ready_state ? addr_oe : ~floated;
    wire [AD_W-1:0] next_ad_out = ready_state ? ad_out : biu_ad;
    wire next_ad_oe = ready_state ? ad_oe : (biu_ad_oe & ~floated);
    wire next_strobe_n = ready_state ? strobe_n : (hold_any | biu_strobe_n);
    wire next_rw_out = ready_state ? rw_out : biu_rw;
    wire next_rw_oe = ready_state ? rw_oe : ~floated;
    wire next_ube_n = ready_state ? upper_byte_enable_n : upper_byte_enable_n_in;
    wire next_ube_oe = ready_state ? ube_oe : ~floated;
    wire next_ale = ready_state ? ale : (~hold_any & biu_ale);
    wire next_ack_n = ready_state ? bus_grant_ack_n : ~ack_low;
    wire [PORT_W-1:0] next_port = (ready_state || hold_any) ? port_four_out :
                                  port_four_in;
    // bus clock pin follows the clock when enabled, else keeps its level
    wire next_clk_pin = clk_pin_en ? phi_s : bus_clk_pin;

    // pin output registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_out <= '0;
            addr_oe <= 1'b0;
            ad_out <= '0;
            ad_oe <= 1'b0;
            strobe_n <= 1'b1;
            rw_out <= 1'b1;
            rw_oe <= 1'b0;
            upper_byte_enable_n <= 1'b1;
            ube_oe <= 1'b0;
            ale <= 1'b0;
            bus_grant_ack_n <= 1'b1;
            port_four_out <= '0;
            bus_clk_pin <= 1'b0;
            bus_clk_oe <= 1'b0;
        end else begin
            addr_out <= next_addr_out;
            addr_oe <= next_addr_oe;
            ad_out <= next_ad_out;
            ad_oe <= next_ad_oe;
            strobe_n <= next_strobe_n;
            rw_out <= next_rw_out;
            rw_oe <= next_rw_oe;
            upper_byte_enable_n <= next_ube_n;
            ube_oe <= next_ube_oe;
            ale <= next_ale;
            bus_grant_ack_n <= next_ack_n;
            port_four_out <= next_port;
            bus_clk_pin <= next_clk_pin;
            bus_clk_oe <= clk_pin_en;
        end
    end

    // hsize is accepted unchecked: only word transfers are issued
    wire unused_ok = &{1'b0, hsize, hwdata[31:8], haddr[31:DEC_W], htrans[0]};
endmodule : ebwrh_top
`default_nettype wire

// ==== test/ebwrh_far.sv ====
// far side model: bus clock source and ready and hold requesters
`timescale 1ns/1ps
`default_nettype none
module ebwrh_far (
    // what the bench wants asserted
    input wire logic want_ready,
    input wire logic want_hold,
    // pins toward the device
    output logic bus_clk_in,
    output logic ready_req_n,
    output logic hold_req_n
);
    // free running bus clock of 320 ns, phase offset from the core clock
    initial begin
        bus_clk_in = 1'b0;
        ready_req_n = 1'b1;
        hold_req_n = 1'b1;
        #7;
        forever #160 bus_clk_in = ~bus_clk_in;
    end
    // requests move only after a rise, clear of the falling sample
    always @(posedge bus_clk_in) begin
        ready_req_n <= !want_ready;
        hold_req_n <= !want_hold;
    end
endmodule : ebwrh_far
`default_nettype wire

// ==== test/ebwrh_properties.sv ====
// assertions on the wait, ready and hold pins
`timescale 1ns/1ps
`default_nettype none
module ebwrh_properties
    import ebwrh_pkg::*;
#(
    parameter int AD_W = 16,
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus unit cycle flags
    input wire logic biu_cycle_start,
    input wire logic biu_ext_area,
    // core clock gates
    input wire logic cpu_clk_run,
    input wire logic int_clk_run,
    input wire logic wdt_run,
    input wire logic wait_stall,
    // bus pins
    input wire logic addr_oe,
    input wire logic [AD_W-1:0] ad_out,
    input wire logic ad_oe,
    input wire logic strobe_n,
    input wire logic rw_oe,
    input wire logic ube_oe,
    input wire logic ale,
    input wire logic bus_grant_ack_n,
    input wire logic [PORT_W-1:0] port_four_out
);
    // one clock domain, reset low disables every check
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    hold_float_a: assert property (!rw_oe |-> strobe_n && !addr_oe && !ad_oe && !ube_oe)
        else $error("bus pins driven while floated");
    ack_pins_a: assert property (!bus_grant_ack_n |-> !ale && strobe_n)
        else $error("latch strobe or strobe wrong under grant");
    hold_stop_a: assert property (!bus_grant_ack_n && !$past(bus_grant_ack_n) |-> !cpu_clk_run && !wdt_run)
        else $error("cpu or watchdog runs under grant");
    float_late_a: assert property ($fell(bus_grant_ack_n) |-> rw_oe [*4])
        else $error("bus floated too early");
    float_due_a: assert property ($fell(bus_grant_ack_n) ##4 (!bus_grant_ack_n && int_clk_run) [*8] |-> !rw_oe)
        else $error("bus not floated one clock after grant");
    redrive_a: assert property ($rose(bus_grant_ack_n) && !rw_oe |-> ##[1:16] rw_oe)
        else $error("bus not driven back after release");
    ready_clk_a: assert property (!int_clk_run |-> !cpu_clk_run)
        else $error("cpu clock runs in ready");
    ready_freeze_a: assert property (!int_clk_run && !$past(int_clk_run) |-> $stable(ad_out) && $stable(ale) && $stable(port_four_out))
        else $error("pins moved in ready");
    hold_ports_a: assert property (!rw_oe && !$past(rw_oe) |-> $stable(port_four_out))
        else $error("port pins moved in hold");
    wait_ext_a: assert property ($rose(wait_stall) |-> $past(biu_cycle_start) && $past(biu_ext_area))
        else $error("wait without external cycle start");
    wait_end_a: assert property ($rose(wait_stall) |-> ##[1:24] !wait_stall)
        else $error("wait too long");
endmodule : ebwrh_properties
`default_nettype wire

// ==== test/test_ext_bus_wait_ready_hold.sv ====
// self-checking bench for the wait, ready and hold block
`timescale 1ns/1ps
`default_nettype none
module test_ext_bus_wait_ready_hold;
    import ebwrh_pkg::*;
    // register byte addresses
    localparam logic [31:0] PM = {22'h0, REG_PMODE_IDX, 2'h0};
    localparam logic [31:0] ST = {22'h0, REG_STAT_IDX, 2'h0};
    logic hclk, hresetn, hsel, hwrite, hready, rd_dp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic want_ready, want_hold, bus_clk_in, ready_req_n, hold_req_n;
    logic biu_busy, biu_last_clk, biu_odd_first, biu_cycle_start, biu_ext_area;
    logic [7:0] biu_addr, port_four_in;
    logic [15:0] biu_ad;
    logic biu_ad_oe, biu_strobe_n, biu_rw, upper_byte_enable_n_in, biu_ale;
    logic [63:0] rnd;
    // observed outputs
    logic cpu_clk_run, int_clk_run, wdt_run, wait_stall, rw_oe, bus_grant_ack_n, bus_clk_oe;
    // wait-bit and area combinations
    logic [1:0] wt [3] = '{2'b11, 2'b10, 2'b01};
    logic [31:0] exp_q[$];
    int err_total, compares;
    ebwrh_far u_far (.want_ready, .want_hold, .bus_clk_in, .ready_req_n, .hold_req_n);
    ebwrh_top u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata,
        .hrdata, .hreadyout(hready), .hresp(), .bus_clk_in, .ready_req_n, .hold_req_n,
        .biu_busy, .biu_last_clk, .biu_odd_first, .biu_cycle_start, .biu_ext_area,
        .biu_addr, .biu_ad, .biu_ad_oe, .biu_strobe_n, .biu_rw, .upper_byte_enable_n_in,
        .biu_ale, .port_four_in, .cpu_clk_run, .int_clk_run, .wdt_run, .wait_stall,
        .addr_out(), .addr_oe(), .ad_out(), .ad_oe(), .strobe_n(), .rw_out(), .rw_oe,
        .upper_byte_enable_n(), .ube_oe(), .ale(), .bus_grant_ack_n, .port_four_out(),
        .bus_clk_pin(), .bus_clk_oe
    );
    // 25 MHz core clock
    always #20 hclk = ~hclk;
    // fresh random bus unit pin values each clock
    always @(posedge hclk) begin
        rnd = {$urandom, $urandom};
        {biu_addr, biu_ad, biu_ad_oe, biu_strobe_n, biu_rw} <= rnd[27:0];
        {upper_byte_enable_n_in, biu_ale, port_four_in} <= rnd[37:28];
    end
    task automatic give_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one single transfer; master holds each phase until ready is sampled
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        rd_dp <= !w;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        rd_dp <= 1'b0;
        if (n >= 50) begin
            err_total++;
            give_verdict();
        end
    endtask : xfer
    // note the expected word, then read
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle
    // at the end of each read data phase, compare with the oldest note
    always @(posedge hclk) begin
        if (rd_dp && hready) begin
            check("hrdata", hrdata, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead);
        end
    end
    initial begin
        void'($urandom(32'ha1be));
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, rd_dp} = '0;
        {want_ready, want_hold, biu_busy, biu_last_clk, biu_cycle_start, biu_ext_area} = '0;
        biu_odd_first = 1'b0;
        {biu_addr, biu_ad, biu_ad_oe, biu_strobe_n, biu_rw} = '0;
        {upper_byte_enable_n_in, biu_ale, port_four_in} = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        idle(4);
        rd(PM, 32'h0);
        rd(ST, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            xfer(PM, 1'b1, d);
            rd(PM, d & 32'h87);
        end
        // unmapped and read-only places
        xfer(32'h100, 1'b1, 32'hff);
        rd(32'h100, 32'h0);
        xfer(ST, 1'b1, 32'hf);
        rd(ST, 32'h0);
        // single-chip mode ignores both request pins
        xfer(PM, 1'b1, 32'h0);
        want_ready <= 1'b1;
        want_hold <= 1'b1;
        idle(40);
        rd(ST, 32'h0);
        check("int_run", 32'(int_clk_run), 32'h1);
        check("clk_oe", 32'(bus_clk_oe), 32'h0);
        want_ready <= 1'b0;
        want_hold <= 1'b0;
        idle(40);
        // hand-over in both bus modes, first blocked mid-cycle or in an odd split's first cycle
        for (int m = 1; m < 3; m++) begin
            xfer(PM, 1'b1, {30'h0, m[1:0]});
            biu_busy <= 1'b1;
            // first blocked: mid-cycle, or last clock of an odd split's first cycle
            biu_last_clk <= (m == 2);
            biu_odd_first <= 1'b1;
            want_hold <= 1'b1;
            idle(40);
            rd(ST, 32'h0);
            biu_last_clk <= 1'b1;
            biu_odd_first <= 1'b0;
            idle(40);
            rd(ST, 32'h6);
            check("rw_oe", 32'(rw_oe), 32'h0);
            check("ack_n", 32'(bus_grant_ack_n), 32'h0);
            check("wdt", 32'(wdt_run), 32'h0);
            check("int_run", 32'(int_clk_run), 32'h1);
            check("clk_oe", 32'(bus_clk_oe), 32'(m == 2));
            biu_busy <= 1'b0;
            want_hold <= 1'b0;
            idle(40);
            rd(ST, 32'h0);
            check("rw_oe", 32'(rw_oe), 32'h1);
        end
        // ready in expansion mode with clock output on; hold waits behind it
        xfer(PM, 1'b1, {24'h0, 1'b1, 5'h0, MODE_EXP});
        want_ready <= 1'b1;
        idle(40);
        check("int_run", 32'(int_clk_run), 32'h0);
        check("wdt", 32'(wdt_run), 32'h1);
        check("clk_oe", 32'(bus_clk_oe), 32'h1);
        want_hold <= 1'b1;
        idle(40);
        rd(ST, 32'h1);
        want_ready <= 1'b0;
        idle(40);
        rd(ST, 32'h6);
        want_hold <= 1'b0;
        idle(40);
        // software wait for each wait-bit and area pairing but both clear
        for (int k = 0; k < 3; k++) begin
            xfer(PM, 1'b1, {29'h0, wt[k][1], MODE_EXP});
            biu_ext_area <= wt[k][0];
            biu_cycle_start <= 1'b1;
            idle(1);
            biu_cycle_start <= 1'b0;
            // look once the edge's updates have settled
            #1;
            check("wait", 32'(wait_stall), 32'(&wt[k]));
            idle(30);
            check("wait_end", 32'(wait_stall), 32'h0);
        end
        give_verdict();
    end
endmodule : test_ext_bus_wait_ready_hold
bind ebwrh_top ebwrh_properties #(.AD_W(AD_W), .PORT_W(PORT_W)) u_props (
    .hclk, .hresetn, .biu_cycle_start, .biu_ext_area, .cpu_clk_run, .int_clk_run,
    .wdt_run, .wait_stall, .addr_oe, .ad_out, .ad_oe, .strobe_n, .rw_oe, .ube_oe, .ale,
    .bus_grant_ack_n, .port_four_out
);
`default_nettype wire
